// File: verilog/output_swing_bypass_control.sv
// Wishbone register bank for output swing selection and retimer bypass
`default_nettype none

// Functional notes
// - Output A mute amplitude, bits 11:8, reset 3, drives output A while muted.
// - Mute amplitude beats rate and bypass amplitudes on each output.
// - Output B bypass amplitude, bits 15:12, reset 3, used while retimer bypassed.
// - Bypass amplitude also used while unlocked, beating every rate amplitude.
// - 5.94 Gb/s amplitude at bits 7:4, reset 3, used for locked 6G data.
// - 2.97 Gb/s amplitude at bits 3:0, reset 3, used for locked 3G data.
// - Output B 1.485 Gb/s amplitude, bits 11:8, reset 3, locked HD data.
// - Output B 0.27 Gb/s amplitude, bits 7:4, reset 3, locked SD data.
// - Output B 0.125 Gb/s amplitude, bits 3:0, reset 3, locked audio data.
// - Manual skip bit 1, reset 0; one routes data around the retimer.
// - Manual skip forces retimer skip whatever the automatic setting.
// - Automatic skip bit 0, reset 1; skips retimer while unlocked when set.
module output_swing_bypass_control
   import swing_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [BUS_W-1:0] wb_dat_i,
   output logic [BUS_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Reclocker status
   input wire logic locked_i,
   input wire rate_t rate_i,
   input wire logic serial_out_a_muted_i,
   input wire logic serial_out_b_muted_i,
   // Output A lower-rate amplitudes from the neighbouring register
   input wire logic [FIELD_W-1:0] out_a_amp_hd_i,
   input wire logic [FIELD_W-1:0] out_a_amp_sd_i,
   input wire logic [FIELD_W-1:0] out_a_amp_audio_i,
   // Driver and retimer control
   output logic [FIELD_W-1:0] serial_out_a_amp_o,
   output logic [FIELD_W-1:0] serial_out_b_amp_o,
   output logic retimer_bypass_o
);

   // ==========================================================
   // Parameter checks
   // Highest index times four must fit in the byte address
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("output_swing_bypass_control: ADDR_W must be 8 to 32");
   end

   // ==========================================================
   // Bus decode
   logic req;
   logic wr;
   logic [ADDR_W-3:0] word_idx;
   logic hit_a_high;
   logic hit_b_low;
   logic hit_b_high;
   logic hit_skip;
   logic [REG_W-1:0] reg_a_high;
   logic [REG_W-1:0] reg_b_low;
   logic [REG_W-1:0] reg_b_high;
   logic [REG_W-1:0] reg_skip;
   logic [REG_W-1:0] rd_word;
   logic next_ack;
   logic [BUS_W-1:0] next_dat;

   function automatic logic idx_is(input logic [ADDR_W-3:0] idx, input int unsigned target);
      idx_is = (idx == target[ADDR_W-3:0]);
   endfunction

   // New request only while no answer is standing
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign word_idx = wb_adr_i[ADDR_W-1:2];
   assign hit_a_high = idx_is(word_idx, IDX_A_HIGH);
   assign hit_b_low = idx_is(word_idx, IDX_B_LOW);
   assign hit_b_high = idx_is(word_idx, IDX_B_HIGH);
   assign hit_skip = idx_is(word_idx, IDX_SKIP);

   always_comb begin
      if (hit_a_high) begin
         rd_word = reg_a_high;
      end else if (hit_b_low) begin
         rd_word = reg_b_low;
      end else if (hit_b_high) begin
         rd_word = reg_b_high;
      end else if (hit_skip) begin
         rd_word = reg_skip;
      end else begin
         // Unmapped words answer normally and read as zero
         rd_word = 16'h0000;
      end
   end

   always_comb begin
      next_ack = req;
      next_dat = wb_dat_o;
      if (req && !wb_we_i) begin
         next_dat = {16'h0000, rd_word};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ==========================================================
   // Registers; reserved bits are masked and always read zero
   swing_reg #(
      .RESET_VAL(RST_A_HIGH),
      .WMASK(MASK_A_HIGH)
   ) u_reg_a_high (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(wr && hit_a_high),
      .sel_i(wb_sel_i[1:0]),
      .wdata_i(wb_dat_i[REG_W-1:0]),
      .value_o(reg_a_high)
   );

   swing_reg #(
      .RESET_VAL(RST_B_LOW),
      .WMASK(MASK_B_LOW)
   ) u_reg_b_low (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(wr && hit_b_low),
      .sel_i(wb_sel_i[1:0]),
      .wdata_i(wb_dat_i[REG_W-1:0]),
      .value_o(reg_b_low)
   );

   swing_reg #(
      .RESET_VAL(RST_B_HIGH),
      .WMASK(MASK_B_HIGH)
   ) u_reg_b_high (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(wr && hit_b_high),
      .sel_i(wb_sel_i[1:0]),
      .wdata_i(wb_dat_i[REG_W-1:0]),
      .value_o(reg_b_high)
   );

   swing_reg #(
      .RESET_VAL(RST_SKIP),
      .WMASK(MASK_SKIP)
   ) u_reg_skip (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(wr && hit_skip),
      .sel_i(wb_sel_i[1:0]),
      .wdata_i(wb_dat_i[REG_W-1:0]),
      .value_o(reg_skip)
   );

   // ==========================================================
   // Retimer bypass
   logic manual_skip;
   logic auto_skip;
   logic bypass_now;
   logic next_bypass;

   assign manual_skip = reg_skip[MANUAL_BIT];
   assign auto_skip = reg_skip[AUTO_BIT];
   // Manual skip wins; automatic skip only acts while unlocked
   assign bypass_now = manual_skip || (auto_skip && !locked_i);

   always_comb begin
      next_bypass = bypass_now;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retimer_bypass_o <= 1'b0;
      end else if (ce_i) begin
         retimer_bypass_o <= next_bypass;
      end
   end

   // ==========================================================
   // Amplitude selection per output
   // Unretimed data, whether bypassed or merely unlocked, uses one field
   logic unretimed;
   assign unretimed = bypass_now || !locked_i;

   amp_select #(
      .AMP_W(FIELD_W)
   ) u_amp_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .muted_i(serial_out_a_muted_i),
      .unretimed_i(unretimed),
      .rate_i(rate_i),
      .amp_6g_i(reg_a_high[AMP_6G_LSB +: FIELD_W]),
      .amp_3g_i(reg_a_high[AMP_3G_LSB +: FIELD_W]),
      .amp_hd_i(out_a_amp_hd_i),
      .amp_sd_i(out_a_amp_sd_i),
      .amp_audio_i(out_a_amp_audio_i),
      .amp_unlocked_i(reg_a_high[UNLOCK_LSB +: FIELD_W]),
      .amp_muted_i(reg_a_high[MUTE_LSB +: FIELD_W]),
      .amp_o(serial_out_a_amp_o)
   );

   amp_select #(
      .AMP_W(FIELD_W)
   ) u_amp_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .muted_i(serial_out_b_muted_i),
      .unretimed_i(unretimed),
      .rate_i(rate_i),
      .amp_6g_i(reg_b_high[AMP_6G_LSB +: FIELD_W]),
      .amp_3g_i(reg_b_high[AMP_3G_LSB +: FIELD_W]),
      .amp_hd_i(reg_b_low[AMP_HD_LSB +: FIELD_W]),
      .amp_sd_i(reg_b_low[AMP_SD_LSB +: FIELD_W]),
      .amp_audio_i(reg_b_low[AMP_AUDIO_LSB +: FIELD_W]),
      .amp_unlocked_i(reg_b_high[UNLOCK_LSB +: FIELD_W]),
      .amp_muted_i(reg_b_high[MUTE_LSB +: FIELD_W]),
      .amp_o(serial_out_b_amp_o)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic run_b;
   assign run_b = ce_i && !serial_out_b_muted_i && !bypass_now && locked_i;

   AST_RESET_VALUES: assert property ($past(rst_i) |-> reg_a_high == RST_A_HIGH
      && reg_b_low == RST_B_LOW && reg_b_high == RST_B_HIGH && reg_skip == RST_SKIP)
      else $error("register reset value wrong");

   AST_A_MUTED: assert property (ce_i && serial_out_a_muted_i
      |=> serial_out_a_amp_o == $past(reg_a_high[MUTE_LSB +: FIELD_W]))
      else $error("output A muted amplitude not applied");

   AST_B_MUTE_OVER_UNLOCK: assert property (ce_i && serial_out_b_muted_i && !locked_i
      |=> serial_out_b_amp_o == $past(reg_b_high[MUTE_LSB +: FIELD_W]))
      else $error("mute did not beat unlocked amplitude");

   AST_B_BYPASS_AMP: assert property (ce_i && !serial_out_b_muted_i && manual_skip
      && locked_i |=> serial_out_b_amp_o == $past(reg_b_high[UNLOCK_LSB +: FIELD_W]))
      else $error("output B bypass amplitude not applied");

   AST_A_UNLOCKED: assert property (ce_i && !serial_out_a_muted_i && !locked_i
      |=> serial_out_a_amp_o == $past(reg_a_high[UNLOCK_LSB +: FIELD_W]))
      else $error("output A unlocked amplitude not applied");

   AST_A_6G: assert property (ce_i && !serial_out_a_muted_i && !bypass_now && locked_i
      && rate_i == RATE_6G |=> serial_out_a_amp_o == $past(reg_a_high[AMP_6G_LSB +: FIELD_W]))
      else $error("output A 6G amplitude wrong");

   AST_B_3G: assert property (run_b && rate_i == RATE_3G
      |=> serial_out_b_amp_o == $past(reg_b_high[AMP_3G_LSB +: FIELD_W]))
      else $error("output B 3G amplitude wrong");

   AST_B_HD: assert property (run_b && rate_i == RATE_HD
      |=> serial_out_b_amp_o == $past(reg_b_low[AMP_HD_LSB +: FIELD_W]))
      else $error("output B HD amplitude wrong");

   AST_B_SD: assert property (run_b && rate_i == RATE_SD
      |=> serial_out_b_amp_o == $past(reg_b_low[AMP_SD_LSB +: FIELD_W]))
      else $error("output B SD amplitude wrong");

   AST_B_AUDIO: assert property (run_b && rate_i == RATE_AUDIO
      |=> serial_out_b_amp_o == $past(reg_b_low[AMP_AUDIO_LSB +: FIELD_W]))
      else $error("output B audio amplitude wrong");

   AST_MANUAL_WRITE: assert property (ce_i && wr && hit_skip && wb_sel_i[0]
      && wb_dat_i[MANUAL_BIT] ##1 ce_i |=> retimer_bypass_o)
      else $error("manual skip write did not bypass retimer");

   // While locked only the manual bit can skip, whatever the automatic bit holds
   AST_MANUAL_OVER_AUTO: assert property (ce_i && manual_skip && locked_i
      |=> retimer_bypass_o)
      else $error("manual skip ignored while locked");

   AST_AUTO_SKIP: assert property (ce_i && !manual_skip
      |=> retimer_bypass_o == ($past(auto_skip) && !$past(locked_i)))
      else $error("automatic skip wrong");

   AST_FREEZE: assert property (!ce_i |=> $stable(retimer_bypass_o) && $stable(wb_ack_o)
      && $stable(serial_out_a_amp_o) && $stable(reg_skip))
      else $error("state moved with clock enable low");

   AST_ACK_PULSE: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   AST_READ_SKIP: assert property (ce_i && req && !wb_we_i && hit_skip
      |=> wb_ack_o && wb_dat_o == {16'h0000, $past(reg_skip)})
      else $error("skip register read back wrong");

   COV_MUTE_A: cover property (ce_i && serial_out_a_muted_i ##1 ce_i && !serial_out_a_muted_i);
   COV_UNLOCK_AUTO: cover property (ce_i && auto_skip && !locked_i ##1 retimer_bypass_o);
   COV_MANUAL: cover property (ce_i && manual_skip && locked_i ##1 retimer_bypass_o);
   COV_RATE_SWEEP: cover property (run_b && rate_i == RATE_HD ##1 run_b && rate_i == RATE_6G);

endmodule

`default_nettype wire

// File: include/swing_pkg.sv
// Shared constants and types for the output swing and retimer bypass registers
`default_nettype none

package swing_pkg;

   // ==========================================================
   // Register geometry
   localparam int unsigned REG_W = 16;
   localparam int unsigned FIELD_W = 4;
   localparam int unsigned BUS_W = 32;

   // ==========================================================
   // Register indices; byte address on the bus is four times the index
   localparam int unsigned IDX_A_HIGH = 32'h0000_001D;
   localparam int unsigned IDX_B_LOW = 32'h0000_001E;
   localparam int unsigned IDX_B_HIGH = 32'h0000_001F;
   localparam int unsigned IDX_SKIP = 32'h0000_0020;

   // ==========================================================
   // Field positions (least significant bit of each field)
   localparam int unsigned UNLOCK_LSB = 12;
   localparam int unsigned MUTE_LSB = 8;
   localparam int unsigned AMP_6G_LSB = 4;
   localparam int unsigned AMP_3G_LSB = 0;
   localparam int unsigned AMP_HD_LSB = 8;
   localparam int unsigned AMP_SD_LSB = 4;
   localparam int unsigned AMP_AUDIO_LSB = 0;
   localparam int unsigned MANUAL_BIT = 1;
   localparam int unsigned AUTO_BIT = 0;

   // ==========================================================
   // Values after reset and writable bits
   localparam logic [REG_W-1:0] RST_A_HIGH = 16'h3333;
   localparam logic [REG_W-1:0] RST_B_LOW = 16'h0333;
   localparam logic [REG_W-1:0] RST_B_HIGH = 16'h3333;
   localparam logic [REG_W-1:0] RST_SKIP = 16'h0001;
   localparam logic [REG_W-1:0] MASK_A_HIGH = 16'hFFFF;
   localparam logic [REG_W-1:0] MASK_B_LOW = 16'h0FFF;
   localparam logic [REG_W-1:0] MASK_B_HIGH = 16'hFFFF;
   localparam logic [REG_W-1:0] MASK_SKIP = 16'h0003;

   // ==========================================================
   // Detected or selected line rate
   typedef enum logic [2:0] {
      RATE_6G,
      RATE_3G,
      RATE_HD,
      RATE_SD,
      RATE_AUDIO
   } rate_t;

endpackage

`default_nettype wire

// File: verilog/swing_reg.sv
// One 16-bit control register with byte-lane writes and a writable-bit mask
`default_nettype none

module swing_reg
   import swing_pkg::*;
#(
   parameter logic [REG_W-1:0] RESET_VAL = 16'h0000,
   parameter logic [REG_W-1:0] WMASK = 16'hFFFF
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Write port
   input wire logic wr_i,
   input wire logic [1:0] sel_i,
   input wire logic [REG_W-1:0] wdata_i,
   // Stored value
   output logic [REG_W-1:0] value_o
);

   logic [REG_W-1:0] lane;
   logic [REG_W-1:0] next_value;

   // Reserved bits must reset to zero or they could never be cleared
   if ((RESET_VAL & ~WMASK) != 16'h0000) begin : g_bad_reset
      $error("swing_reg: reset value sets bits that are not writable");
   end

   always_comb begin
      lane = {{8{sel_i[1]}}, {8{sel_i[0]}}} & WMASK;
      next_value = value_o;
      if (wr_i) begin
         next_value = (value_o & ~lane) | (wdata_i & lane);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_o <= RESET_VAL;
      end else if (ce_i) begin
         value_o <= next_value;
      end
   end

endmodule

`default_nettype wire

// File: verilog/amp_select.sv
// Picks the drive amplitude of one serial output by mute, bypass and rate
`default_nettype none

module amp_select
   import swing_pkg::*;
#(
   parameter int AMP_W = 4
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Output state
   input wire logic muted_i,
   input wire logic unretimed_i,
   input wire rate_t rate_i,
   // Amplitude fields
   input wire logic [AMP_W-1:0] amp_6g_i,
   input wire logic [AMP_W-1:0] amp_3g_i,
   input wire logic [AMP_W-1:0] amp_hd_i,
   input wire logic [AMP_W-1:0] amp_sd_i,
   input wire logic [AMP_W-1:0] amp_audio_i,
   input wire logic [AMP_W-1:0] amp_unlocked_i,
   input wire logic [AMP_W-1:0] amp_muted_i,
   // Chosen amplitude
   output logic [AMP_W-1:0] amp_o
);

   logic [AMP_W-1:0] next_amp;

   if (AMP_W != int'(FIELD_W)) begin : g_bad_width
      $error("amp_select: amplitude width must match the register fields");
   end

   always_comb begin
      if (muted_i) begin
         next_amp = amp_muted_i;
      end else if (unretimed_i) begin
         next_amp = amp_unlocked_i;
      end else begin
         case (rate_i)
            RATE_6G: next_amp = amp_6g_i;
            RATE_3G: next_amp = amp_3g_i;
            RATE_HD: next_amp = amp_hd_i;
            RATE_SD: next_amp = amp_sd_i;
            RATE_AUDIO: next_amp = amp_audio_i;
            // Unknown rate code: fall back to the unretimed amplitude
            default: next_amp = amp_unlocked_i;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         amp_o <= RST_A_HIGH[AMP_3G_LSB +: AMP_W];
      end else if (ce_i) begin
         amp_o <= next_amp;
      end
   end

endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the output swing and retimer bypass register bank
`default_nettype none

module tb_top import swing_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic locked = 1'b1;
   rate_t rate = RATE_6G;
   logic mute_a = 1'b0;
   logic mute_b = 1'b0;
   logic [3:0] a_hd = 4'h4;
   logic [3:0] a_sd = 4'hA;
   logic [3:0] a_audio = 4'hF;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] amp_a;
   logic [3:0] amp_b;
   logic bypass;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;

   output_swing_bypass_control #(.ADDR_W(8)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .locked_i(locked), .rate_i(rate),
      .serial_out_a_muted_i(mute_a), .serial_out_b_muted_i(mute_b),
      .out_a_amp_hd_i(a_hd), .out_a_amp_sd_i(a_sd), .out_a_amp_audio_i(a_audio),
      .serial_out_a_amp_o(amp_a), .serial_out_b_amp_o(amp_b),
      .retimer_bypass_o(bypass)
   );

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // ==========================================================
   // Shared tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("unexpected hang after %0d cycles", cycles);
         tally_and_finish();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled, release at that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      check("bus ack", {31'h0000_0000, wb_ack_o}, 32'h0000_0001);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, 4'h3, d, q);
   endtask

   task automatic chk_reg(input string name, input logic [7:0] a, input logic [15:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 4'h3, 16'h0000, q);
      check(name, q, {16'h0000, exp});
   endtask

   // Outputs are registered; two edges leave them steady
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic status(input logic l, input logic ma, input logic mb, input rate_t r);
      @(posedge clk_i);
      locked <= l;
      mute_a <= ma;
      mute_b <= mb;
      rate <= r;
      settle();
   endtask

   task automatic chk_out(input logic [3:0] ea, input logic [3:0] eb, input logic ebp);
      check("amp a", {28'h000_0000, amp_a}, {28'h000_0000, ea});
      check("amp b", {28'h000_0000, amp_b}, {28'h000_0000, eb});
      check("retimer bypass", {31'h0000_0000, bypass}, {31'h0000_0000, ebp});
   endtask

   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk_reg("reg a high", 8'h74, 16'h3333);
      chk_reg("reg b low", 8'h78, 16'h0333);
      chk_reg("reg b high", 8'h7C, 16'h3333);
      chk_reg("reg skip", 8'h80, 16'h0001);
      chk_reg("unmapped", 8'h84, 16'h0000);
      settle();
      chk_out(4'h3, 4'h3, 1'b0);
   endtask

   task automatic t_access;
      // Software keeps reserved bits of mapped registers at zero, so only their writable bits are set
      wr(8'h74, 16'hFFFF);
      wr(8'h78, 16'h0FFF);
      wr(8'h7C, 16'hFFFF);
      wr(8'h80, 16'h0003);
      wr(8'h84, 16'hFFFF);
      chk_reg("reg a high rw", 8'h74, 16'hFFFF);
      chk_reg("reg b low rw", 8'h78, 16'h0FFF);
      chk_reg("reg b high rw", 8'h7C, 16'hFFFF);
      chk_reg("reg skip rw", 8'h80, 16'h0003);
      chk_reg("unmapped write", 8'h84, 16'h0000);
      // Distinct values so a wrong field pick cannot hide
      wr(8'h74, 16'hDC12);
      wr(8'h78, 16'h0567);
      wr(8'h7C, 16'hEB89);
      wr(8'h80, 16'h0001);
      begin
         logic [31:0] q;
         bus(1'b1, 8'h74, 4'h1, 16'h0000, q);
      end
      chk_reg("low lane only", 8'h74, 16'hDC00);
      wr(8'h74, 16'hDC12);
   endtask

   task automatic t_rate;
      logic [3:0] ea [8];
      logic [3:0] eb [8];
      ea = '{4'h1, 4'h2, 4'h4, 4'hA, 4'hF, 4'hD, 4'hD, 4'hD};
      eb = '{4'h8, 4'h9, 4'h5, 4'h6, 4'h7, 4'hE, 4'hE, 4'hE};
      for (int r = 0; r < 8; r++) begin
         status(1'b1, 1'b0, 1'b0, rate_t'(r[2:0]));
         chk_out(ea[r], eb[r], 1'b0);
      end
   endtask

   task automatic t_mute;
      status(1'b1, 1'b1, 1'b0, RATE_HD);
      chk_out(4'hC, 4'h5, 1'b0);
      status(1'b0, 1'b1, 1'b1, RATE_HD);
      chk_out(4'hC, 4'hB, 1'b1);
      wr(8'h80, 16'h0002);
      status(1'b1, 1'b0, 1'b1, RATE_SD);
      chk_out(4'hD, 4'hB, 1'b1);
   endtask

   task automatic t_bypass;
      wr(8'h80, 16'h0000);
      status(1'b0, 1'b0, 1'b0, RATE_6G);
      chk_out(4'hD, 4'hE, 1'b0);
      status(1'b1, 1'b0, 1'b0, RATE_6G);
      chk_out(4'h1, 4'h8, 1'b0);
      wr(8'h80, 16'h0002);
      settle();
      chk_out(4'hD, 4'hE, 1'b1);
      wr(8'h80, 16'h0003);
      status(1'b0, 1'b0, 1'b0, RATE_3G);
      chk_out(4'hD, 4'hE, 1'b1);
      wr(8'h80, 16'h0001);
      status(1'b1, 1'b0, 1'b0, RATE_3G);
      chk_out(4'h2, 4'h9, 1'b0);
   endtask

   // Clock enable low must freeze the outputs
   task automatic t_ce;
      @(posedge clk_i);
      ce_i <= 1'b0;
      status(1'b0, 1'b0, 1'b0, RATE_3G);
      chk_out(4'h2, 4'h9, 1'b0);
      @(posedge clk_i);
      ce_i <= 1'b1;
      settle();
      chk_out(4'hD, 4'hE, 1'b1);
   endtask

   task automatic t_rereset;
      status(1'b1, 1'b0, 1'b0, RATE_6G);
      do_reset();
      chk_reg("reg b high again", 8'h7C, 16'h3333);
      chk_reg("reg skip again", 8'h80, 16'h0001);
      settle();
      chk_out(4'h3, 4'h3, 1'b0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      do_reset();
      t_reset();
      t_access();
      t_rate();
      t_mute();
      t_bypass();
      t_ce();
      t_rereset();
      tally_and_finish();
   end
endmodule

`default_nettype wire
